// [rtl/txcd_decoder.sv]
// transmit buffer command decoder
// assumes the host writes fifo words as single-cycle strobes on one clock
`timescale 1ns/100ps
`default_nettype none
module txcd_decoder (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wr_valid,
  input  wire logic [31:0] wr_data,
  input  wire logic        checksum_engine_enable,
  input  wire logic        err_clear,
  output logic             data_valid,
  output logic      [31:0] data_word,
  output logic             data_first,
  output logic      [4:0]  start_offset,
  output logic             first_segment_flag,
  output logic             last_segment,
  output logic             buffer_loaded_flag,
  output logic             transmit_error_flag,
  output logic      [15:0] status_tag,
  output logic             status_valid,
  output logic             checksum_enable,
  output logic             crc_append,
  output logic             pad_enable,
  output logic      [10:0] packet_length
);
  import txcd_pkg::*;

  // ==========================================================
  // state and registers
  txcd_state_t state_reg, state_next;
  logic [31:0] cmda_reg;
  logic [31:0] cmdb_reg;
  logic [31:0] pkt_b_reg;
  logic        in_pkt_reg;
  logic [11:0] sum_reg;
  logic [9:0]  cnt_reg;
  logic [9:0]  pad_reg;
  logic        irq_reg;
  logic        first_word_reg;

  // ==========================================================
  // decode of the latched command word a
  logic [4:0]        a_offs;
  logic [1:0]        a_align;
  logic [SIZE_W-1:0] a_size;
  logic [9:0]        dw_words;
  logic [9:0]        pw_words;
  logic              a_first;
  logic              a_last;

  assign a_offs  = cmda_reg[A_OFFS_HI:A_OFFS_LO];
  assign a_align = cmda_reg[A_ALIGN_HI:A_ALIGN_LO];
  assign a_size  = cmda_reg[SIZE_HI:0];
  assign a_first = cmda_reg[A_FIRST_BIT];
  assign a_last  = cmda_reg[A_LAST_BIT];

  // dword counts of this buffer
  txcd_word_count txcd_word_count_inst (
    .offset     (a_offs),
    .size       (a_size),
    .align      (a_align),
    .data_words (dw_words),
    .pad_words  (pw_words)
  );

  // ==========================================================
  // event decoding on fifo word arrival
  logic        take_a;
  logic        take_b;
  logic        take_d;
  logic        take_p;
  logic        b_mismatch;
  logic [11:0] sum_new;
  logic        len_bad;
  logic        buf_end;
  logic        set_err;

  assign take_a     = wr_valid && (state_reg == ST_CMDA);
  assign take_b     = wr_valid && (state_reg == ST_CMDB);
  assign take_d     = wr_valid && (state_reg == ST_DATA);
  assign take_p     = wr_valid && (state_reg == ST_PAD);
  // a non-first buffer must carry the same word b
  assign b_mismatch = take_b && !a_first && in_pkt_reg && (wr_data != pkt_b_reg);
  assign sum_new    = (a_first ? 12'h000 : sum_reg) + 12'(a_size);
  assign len_bad    = take_b && a_last &&
                      (sum_new != {1'b0, wr_data[SIZE_HI:0]});
  // buffer ends on last data word if no padding, else last pad word, or on word b when there are neither data words nor pad words
  assign buf_end    = (take_d && cnt_reg == 10'h001 && pad_reg == 10'h000) ||
                      (take_p && cnt_reg == 10'h001) ||
                      (take_b && dw_words == 10'h000 && pw_words == 10'h000);
  assign set_err    = b_mismatch || len_bad;

  // next state selection
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_CMDA: if (wr_valid) state_next = ST_CMDB;
      ST_CMDB: begin
        if (wr_valid) begin
          if (dw_words != 10'h000) state_next = ST_DATA;
          else if (pw_words != 10'h000) state_next = ST_PAD;
          else state_next = ST_CMDA;
        end
      end
      ST_DATA: begin
        if (wr_valid && cnt_reg == 10'h001)
          state_next = (pad_reg != 10'h000) ? ST_PAD : ST_CMDA;
      end
      ST_PAD: if (wr_valid && cnt_reg == 10'h001) state_next = ST_CMDA;
      default: state_next = ST_CMDA;
    endcase
  end

  // ==========================================================
  // state and command capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_CMDA;
      cmda_reg  <= 32'h0000_0000;
      cmdb_reg  <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      if (take_a) cmda_reg <= wr_data;
      if (take_b) cmdb_reg <= wr_data;
    end
  end

  // packet tracking and byte sum
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pkt_b_reg  <= 32'h0000_0000;
      in_pkt_reg <= 1'b0;
      sum_reg    <= 12'h000;
    end else if (take_b) begin
      if (a_first) pkt_b_reg <= wr_data;
      in_pkt_reg <= !a_last;
      sum_reg    <= sum_new;
    end
  end

  // data and padding word counters
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg        <= 10'h000;
      pad_reg        <= 10'h000;
      irq_reg        <= 1'b0;
      first_word_reg <= 1'b0;
    end else if (take_b) begin
      cnt_reg        <= (dw_words != 10'h000) ? dw_words : pw_words;
      pad_reg        <= pw_words;
      irq_reg        <= cmda_reg[A_IRQ_BIT];
      first_word_reg <= 1'b1;
    end else if (take_d) begin
      first_word_reg <= 1'b0;
      cnt_reg        <= (cnt_reg == 10'h001) ? pad_reg : cnt_reg - 10'h001;
    end else if (take_p) begin
      cnt_reg <= cnt_reg - 10'h001;
    end
  end

  // ==========================================================
  // data stream out, padding words never forwarded
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_valid   <= 1'b0;
      data_word    <= 32'h0000_0000;
      data_first   <= 1'b0;
      start_offset <= 5'h00;
    end else begin
      data_valid <= take_d;
      if (take_d) begin
        data_word    <= wr_data;
        data_first   <= first_word_reg;
        start_offset <= a_offs;
      end
    end
  end

  // segment flags and loaded event
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      first_segment_flag <= 1'b0;
      last_segment       <= 1'b0;
      buffer_loaded_flag <= 1'b0;
    end else begin
      if (take_b) begin
        first_segment_flag <= a_first;
        last_segment       <= a_last;
      end
      buffer_loaded_flag <= buf_end && (take_b ? cmda_reg[A_IRQ_BIT] : irq_reg);
    end
  end

  // sticky error, set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) transmit_error_flag <= 1'b0;
    else if (set_err) transmit_error_flag <= 1'b1;
    else if (err_clear) transmit_error_flag <= 1'b0;
  end

  // ==========================================================
  // per-packet controls from word b
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_tag      <= 16'h0000;
      status_valid    <= 1'b0;
      checksum_enable <= 1'b0;
      crc_append      <= 1'b1;
      pad_enable      <= 1'b1;
      packet_length   <= 11'h000;
    end else begin
      status_valid <= take_b && a_last;
      if (take_b) begin
        status_tag      <= wr_data[B_TAG_HI:B_TAG_LO];
        checksum_enable <= wr_data[B_CSUM_BIT] && a_first &&
                           checksum_engine_enable;
        crc_append      <= !wr_data[B_NOCRC_BIT] || wr_data[B_NOPAD_BIT];
        pad_enable      <= !wr_data[B_NOPAD_BIT];
        packet_length   <= wr_data[SIZE_HI:0];
      end
    end
  end

  // ==========================================================
  // checks
  property p_mismatch_err;
    @(posedge clk) disable iff (!rst_n)
      b_mismatch |=> transmit_error_flag;
  endproperty
  a_mismatch_err: assert property (p_mismatch_err) else $error("b mismatch missed");

  property p_len_err;
    @(posedge clk) disable iff (!rst_n)
      len_bad |=> transmit_error_flag;
  endproperty
  a_len_err: assert property (p_len_err) else $error("length error not flagged");

  property p_loaded;
    @(posedge clk) disable iff (!rst_n)
      buffer_loaded_flag |-> $past(buf_end);
  endproperty
  a_loaded: assert property (p_loaded) else $error("loaded flag without buffer end");

  property p_pad_drop;
    @(posedge clk) disable iff (!rst_n)
      take_p |=> !data_valid;
  endproperty
  a_pad_drop: assert property (p_pad_drop) else $error("pad word forwarded");

  property p_csum;
    @(posedge clk) disable iff (!rst_n)
      (take_b && !a_first) |=> !checksum_enable;
  endproperty
  a_csum: assert property (p_csum) else $error("checksum without first segment");

  property p_crc;
    @(posedge clk) disable iff (!rst_n)
      (take_b && wr_data[B_NOCRC_BIT] && !wr_data[B_NOPAD_BIT]) |=> !crc_append;
  endproperty
  a_crc: assert property (p_crc) else $error("crc not disabled");

  property p_nopad_crc;
    @(posedge clk) disable iff (!rst_n)
      !pad_enable |-> crc_append;
  endproperty
  a_nopad_crc: assert property (p_nopad_crc) else $error("crc dropped, no padding");

  property p_tag;
    @(posedge clk) disable iff (!rst_n)
      take_b |=> (status_tag == $past(wr_data[B_TAG_HI:B_TAG_LO])) &&
                 (pad_enable == !$past(wr_data[B_NOPAD_BIT]));
  endproperty
  a_tag: assert property (p_tag) else $error("tag or pad control wrong");

  property p_seg_flags;
    @(posedge clk) disable iff (!rst_n)
      take_b |=> (first_segment_flag == $past(a_first)) && (last_segment == $past(a_last));
  endproperty
  a_seg_flags: assert property (p_seg_flags) else $error("segment flags wrong");

  property p_status;
    @(posedge clk) disable iff (!rst_n)
      take_b |=> (status_valid == $past(a_last));
  endproperty
  a_status: assert property (p_status) else $error("status pulse wrong");

  property p_offset;
    @(posedge clk) disable iff (!rst_n)
      take_d |=> (start_offset == $past(a_offs)) && (data_word == $past(wr_data));
  endproperty
  a_offset: assert property (p_offset) else $error("data word or offset wrong");

  property p_err_sticky;
    @(posedge clk) disable iff (!rst_n)
      (transmit_error_flag && !err_clear) |=> transmit_error_flag;
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("error flag dropped");

endmodule
`default_nettype wire

// [rtl/txcd_pkg.sv]
// package for the transmit buffer command decoder
// assumes a single 10 MHz clock domain and 32-bit fifo words
`default_nettype none
package txcd_pkg;

  // ==========================================================
  // command word a fields
  localparam int A_IRQ_BIT      = 31;
  localparam int A_ALIGN_HI     = 25;
  localparam int A_ALIGN_LO     = 24;
  localparam int A_OFFS_HI      = 20;
  localparam int A_OFFS_LO      = 16;
  localparam int A_FIRST_BIT    = 13;
  localparam int A_LAST_BIT     = 12;
  localparam int SIZE_HI        = 10;
  localparam int SIZE_W         = 11;

  // ==========================================================
  // command word b fields
  localparam int B_TAG_HI       = 31;
  localparam int B_TAG_LO       = 16;
  localparam int B_CSUM_BIT     = 14;
  localparam int B_NOCRC_BIT    = 13;
  localparam int B_NOPAD_BIT    = 12;

  // ==========================================================
  // end alignment codes and sizes
  localparam logic [1:0] ALIGN_4  = 2'h0;
  localparam logic [1:0] ALIGN_16 = 2'h1;
  localparam logic [1:0] ALIGN_32 = 2'h2;
  localparam int MIN_FRAME_BYTES  = 64;

  // ==========================================================
  // decoder states
  typedef enum logic [3:0] {
    ST_CMDA = 4'h1,
    ST_CMDB = 4'h2,
    ST_DATA = 4'h4,
    ST_PAD  = 4'h8
  } txcd_state_t;

endpackage
`default_nettype wire

// [rtl/txcd_word_count.sv]
// word count calculator for one transmit buffer
// assumes fields are already extracted from command word a
`timescale 1ns/100ps
`default_nettype none
module txcd_word_count (
  input  wire logic [4:0]                  offset,
  input  wire logic [txcd_pkg::SIZE_W-1:0] size,
  input  wire logic [1:0]                  align,
  output logic      [9:0]                  data_words,
  output logic      [9:0]                  pad_words
);
  import txcd_pkg::*;

  // ==========================================================
  // data and padding dword counts
  logic [12:0] span;
  logic [9:0]  amask;
  logic [9:0]  total;

  // offset plus size rounded to dwords
  assign span       = 13'(offset) + 13'(size) + 13'h0003;
  assign data_words = span[11:2];
  // alignment mask in dwords
  assign amask      = (align == ALIGN_32) ? 10'h007 :
                      (align == ALIGN_16) ? 10'h003 : 10'h000;
  assign total      = (data_words + amask) & ~amask;
  assign pad_words  = total - data_words;

endmodule
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the transmit buffer command decoder
// assumes the host model drives the fifo port and the bench drives the rest
`timescale 1ns/100ps
`default_nettype none
module tb;
  import txcd_pkg::*;

  // ==========================================================
  // signals
  logic        clk;
  logic        rst_n;
  logic        err_clear;
  logic        checksum_engine_enable;
  logic        wr_valid;
  logic [31:0] wr_data;
  logic        data_valid;
  logic [31:0] data_word;
  logic        data_first;
  logic [4:0]  start_offset;
  logic        first_segment_flag;
  logic        last_segment;
  logic        buffer_loaded_flag;
  logic        transmit_error_flag;
  logic [15:0] status_tag;
  logic        status_valid;
  logic        checksum_enable;
  logic        crc_append;
  logic        pad_enable;
  logic [10:0] packet_length;
  int          failures;
  int          tests_run;
  int          n_data;
  int          n_loaded;
  int          n_status;
  logic [31:0] first_word;
  logic [15:0] tag_seen;
  logic [4:0]  offs [3] = '{5'h03, 5'h03, 5'h1F};
  logic [10:0] sizes [3] = '{11'h005, 11'h005, 11'h001};
  int          ndw [3] = '{2, 2, 8};

  txcd_decoder txcd_decoder_inst (.clk(clk), .rst_n(rst_n), .wr_valid(wr_valid),
    .wr_data(wr_data), .checksum_engine_enable(checksum_engine_enable),
    .err_clear(err_clear), .data_valid(data_valid), .data_word(data_word),
    .data_first(data_first), .start_offset(start_offset),
    .first_segment_flag(first_segment_flag), .last_segment(last_segment),
    .buffer_loaded_flag(buffer_loaded_flag), .transmit_error_flag(transmit_error_flag),
    .status_tag(status_tag), .status_valid(status_valid),
    .checksum_enable(checksum_enable), .crc_append(crc_append),
    .pad_enable(pad_enable), .packet_length(packet_length));

  txcd_host_model txcd_host_model_inst (.clk(clk), .wr_valid(wr_valid), .wr_data(wr_data));

  // ==========================================================
  // clock, monitor, watchdog
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // counts one-cycle pulses settled at the falling edge
  always @(negedge clk) begin
    if (data_valid === 1'b1) n_data++;
    if (data_valid === 1'b1 && data_first === 1'b1) first_word = data_word;
    if (buffer_loaded_flag === 1'b1) n_loaded++;
    if (status_valid === 1'b1) begin
      n_status++;
      tag_seen = status_tag;
    end
  end

  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    tally_and_finish();
  end

  // ==========================================================
  // tasks
  function automatic logic [31:0] mk_b(input logic [15:0] tag, input logic ck,
                                       input logic nocrc, input logic nopad,
                                       input logic [10:0] len);
    return {tag, 1'b0, ck, nocrc, nopad, 1'b0, len};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic run(input logic irq, input logic [1:0] al, input logic [4:0] off,
                     input logic fs, input logic ls, input logic [10:0] sz,
                     input logic [31:0] b);
    @(posedge clk);
    n_data = 0;
    n_loaded = 0;
    n_status = 0;
    txcd_host_model_inst.send_buffer(irq, al, off, fs, ls, sz, b);
    repeat (3) @(negedge clk);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================
  // test sequence
  initial begin
    failures = 0;
    tests_run = 0;
    rst_n = 1'b0;
    err_clear = 1'b0;
    checksum_engine_enable = 1'b1;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    chk(crc_append, 1);
    chk(pad_enable, 1);
    $display("test reset done");
    run(1'b1, ALIGN_4, 5'h00, 1'b1, 1'b1, 11'h008, mk_b(16'h1234, 1'b1, 1'b0, 1'b0, 11'h008));
    chk(n_data, 2);
    chk(n_loaded, 1);
    chk(tag_seen, 32'h0000_1234);
    chk(first_word, 32'hD000_0000);
    chk(first_segment_flag, 1);
    chk(last_segment, 1);
    chk(checksum_enable, 1);
    chk(packet_length, 32'h0000_0008);
    chk(transmit_error_flag, 0);
    $display("test single buffer done");
    for (int k = 0; k < 3; k++) begin
      checksum_engine_enable = (k == 1);
      run(1'b0, 2'(k), offs[k], 1'b1, 1'b1, sizes[k],
          mk_b(16'h0100, 1'b1, k != 1, k != 0, sizes[k]));
      chk(n_data, ndw[k]);
      chk(n_loaded, 0);
      chk(start_offset, offs[k]);
      chk(checksum_enable, k == 1);
      chk(crc_append, k != 0);
      chk(pad_enable, k == 0);
    end
    $display("test alignment and controls done");
    checksum_engine_enable = 1'b1;
    run(1'b1, ALIGN_4, 5'h00, 1'b1, 1'b0, 11'h005, mk_b(16'hBEEF, 1'b1, 1'b0, 1'b0, 11'h008));
    chk(n_status, 0);
    chk(last_segment, 0);
    run(1'b1, ALIGN_16, 5'h01, 1'b0, 1'b1, 11'h003, mk_b(16'hBEEF, 1'b1, 1'b0, 1'b0, 11'h008));
    chk(n_data, 1);
    chk(n_loaded, 1);
    chk(n_status, 1);
    chk(tag_seen, 32'h0000_BEEF);
    chk(first_segment_flag, 0);
    chk(transmit_error_flag, 0);
    $display("test two segments done");
    run(1'b1, ALIGN_4, 5'h00, 1'b1, 1'b1, 11'h004, mk_b(16'h0001, 1'b0, 1'b0, 1'b0, 11'h006));
    chk(transmit_error_flag, 1);
    err_clear = 1'b1;
    @(negedge clk);
    err_clear = 1'b0;
    @(negedge clk);
    chk(transmit_error_flag, 0);
    $display("test length mismatch done");
    run(1'b0, ALIGN_4, 5'h00, 1'b1, 1'b0, 11'h004, mk_b(16'h0002, 1'b0, 1'b0, 1'b0, 11'h008));
    run(1'b0, ALIGN_4, 5'h00, 1'b0, 1'b1, 11'h004, mk_b(16'h0003, 1'b0, 1'b0, 1'b0, 11'h008));
    chk(transmit_error_flag, 1);
    $display("test command b mismatch done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// [tb/txcd_host_model.sv]
// host model writing command pairs, data and padding into the fifo port
// assumes one caller at a time and words launched at the falling edge
`timescale 1ns/100ps
`default_nettype none
module txcd_host_model (
  input  wire logic        clk,
  output logic             wr_valid,
  output logic      [31:0] wr_data
);
  import txcd_pkg::*;

  // ==========================================================
  // idle bus
  initial begin
    wr_valid = 1'b0;
    wr_data  = 32'h0000_0000;
  end

  // one word per cycle
  task automatic put(input logic [31:0] w);
    @(negedge clk);
    wr_valid = 1'b1;
    wr_data  = w;
  endtask

  // command pair, data dwords, then host padding up to the alignment
  task automatic send_buffer(input logic irq, input logic [1:0] al, input logic [4:0] off,
                             input logic fs, input logic ls, input logic [10:0] sz,
                             input logic [31:0] b);
    int d;
    int m;
    int t;
    d = (int'(off) + int'(sz) + 3) / 4;
    m = (al == ALIGN_16) ? 4 : ((al == ALIGN_32) ? 8 : 1);
    t = ((d + m - 1) / m) * m;
    put({irq, 5'h00, al, 3'h0, off, 2'h0, fs, ls, 1'b0, sz});
    put(b);
    for (int i = 0; i < t; i++) begin
      put((i < d) ? (32'hD000_0000 | 32'(i)) : 32'hEEEE_0000);
    end
    @(negedge clk);
    wr_valid = 1'b0;
    wr_data  = ~wr_data; // released bus never shows a stale word
  endtask
endmodule
`default_nettype wire
